// ===== pkg/srsr_defs.svh
/*
  constants for the stream-read status reporter: task-file addresses,
  field positions, opcode and timing counts.
  assumes a 250 MHz ref_clk.
*/
`ifndef SRSR_DEFS_SVH
`define SRSR_DEFS_SVH

// command block addresses (control block uses the same 3 address pins)
`define SRSR_A_DATA 3'h0
`define SRSR_A_ERRFEAT 3'h1
`define SRSR_A_COUNT 3'h2
`define SRSR_A_SECT 3'h3
`define SRSR_A_CYLLO 3'h4
`define SRSR_A_CYLHI 3'h5
`define SRSR_A_DEV 3'h6
`define SRSR_A_STATCMD 3'h7
`define SRSR_A_DEVCTL 3'h6

`define SRSR_OP_READ_STREAM 8'h2b

// field positions
`define SRSR_FEAT_RC 6
`define SRSR_DEVCTL_HOB 7
`define SRSR_ST_BSY 7
`define SRSR_ST_RDY 6
`define SRSR_ST_SE 5
`define SRSR_ST_DWE 4
`define SRSR_ST_ERR 0
`define SRSR_ER_ABRT 2
`define SRSR_ER_COMPLETION_LIMIT_TIMEOUT_FLAG 0

// reset value and zero-count sector total
`define SRSR_TF_RST 8'h00
`define SRSR_CNT_MAX 17'h10000

// timing
`define SRSR_CLK_PERIOD_NS 4
`define SRSR_US_NS 1000
`define SRSR_CYC_PER_US (`SRSR_US_NS / `SRSR_CLK_PERIOD_NS)

`endif

// ===== pkg/srsr_pkg.sv
/*
  types for the stream-read status reporter.
  assumes srsr_defs.svh is not needed here.
*/
package srsr_pkg;

  typedef enum logic [1:0] {
    SRSR_IDLE = 2'b00,
    SRSR_BUSY = 2'b01
  } srsr_state_t;

  // one sector event from the media path, same clock
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] err_bits;
    logic [47:0] lba;
  } srsr_media_t;

  // host task-file pins as sampled
  typedef struct packed {
    logic ctl_sel;
    logic [2:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] din;
  } srsr_hbus_t;

endpackage : srsr_pkg

// ===== design/srsr_completion_time_limit_timer.sv
/*
  completion-time-limit timer: counts microseconds from start until
  limit*UNIT_US, then pulses expired once.
  assumes start and stop come from logic on ref_clk.
*/
`timescale 1ns/1ns
`include "srsr_defs.svh"

module srsr_completion_time_limit_timer #(
  parameter int unsigned UNIT_US = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] limit,
  output logic expired
);

  localparam logic [7:0] PRE_LAST = 8'(`SRSR_CYC_PER_US - 1);

  logic run;
  logic [7:0] pre;
  logic [31:0] us_cnt;
  logic [31:0] target;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run <= 1'b0;
      pre <= 8'h00;
      us_cnt <= 32'h0;
      target <= 32'h0;
      expired <= 1'b0;
    end else if (start) begin
      // zero limit means no limit is enforced
      run <= (limit != 8'h00);
      target <= 32'(32'(limit) * UNIT_US);
      pre <= 8'h00;
      us_cnt <= 32'h0;
      expired <= 1'b0;
    end else if (stop) begin
      run <= 1'b0;
      expired <= 1'b0;
    end else if (run) begin
      expired <= 1'b0;
      if (pre == PRE_LAST) begin
        pre <= 8'h00;
        us_cnt <= us_cnt + 32'h1;
        if (us_cnt + 32'h1 == target) begin
          run <= 1'b0;
          expired <= 1'b1;
        end
      end else begin
        pre <= pre + 8'h01;
      end
    end else begin
      expired <= 1'b0;
    end
  end

  a_no_early_expiry: assert property (@(posedge ref_clk) disable iff (rst)
    start |=> !expired [*8]) else $error("limit expired too soon");
  a_expiry_ends_run: assert property (@(posedge ref_clk) disable iff (rst)
    expired |-> !run && $past(run)) else $error("expiry without run");

endmodule : srsr_completion_time_limit_timer

// ===== design/srsr_top.sv
/*
  stream-read status reporter: task-file registers, read stream command
  tracking and ending status with first-error address reporting.
  assumes host pins are asynchronous; media events and the deferred write
  event come from logic on ref_clk.
*/
`timescale 1ns/1ns
`include "srsr_defs.svh"

module srsr_top #(
  parameter int unsigned COMPLETION_TIME_LIMIT_UNIT_US = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hst_ctl_sel,
  input wire logic [2:0] hst_addr,
  input wire logic hst_rd_n,
  input wire logic hst_wr_n,
  input wire logic [7:0] hst_din,
  output logic [7:0] hst_dout,
  output logic hst_doe,
  output logic intrq,
  input wire srsr_pkg::srsr_media_t media,
  input wire logic dwe_event,
  output logic xfer_active,
  output logic log_valid,
  output logic [7:0] log_bits
);

  localparam srsr_pkg::srsr_hbus_t HB_IDLE = '{1'b0, 3'h0, 1'b1, 1'b1, 8'h00};

  // byte lane of the 48-bit address for sect/cyllo/cylhi under a HOB view
  function automatic int lane_of(input int idx, input logic hob);
    lane_of = hob ? idx + 3 : idx;
  endfunction : lane_of

  srsr_pkg::srsr_hbus_t hb_s1, hb_s2, hb_q;
  srsr_pkg::srsr_state_t state;
  logic [7:0] tf_cur [0:4];
  logic [7:0] tf_prev [0:4];
  logic [7:0] dev_head;
  logic hob;
  logic rc;
  logic [16:0] requested, done_cnt;
  logic err_seen, in_run;
  logic [47:0] first_lba;
  logic [15:0] run_len;
  logic [7:0] err_acc, err_reg;
  logic st_se, st_dwe, st_err, dwe_pend;
  logic tmo;

  // pins pass two flops; edges taken between second stage and its copy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hb_s1 <= HB_IDLE;
      hb_s2 <= HB_IDLE;
      hb_q <= HB_IDLE;
    end else begin
      hb_s1 <= '{hst_ctl_sel, hst_addr, hst_rd_n, hst_wr_n, hst_din};
      hb_s2 <= hb_s1;
      hb_q <= hb_s2;
    end
  end

  logic rd_fall, wr_rise, idle, cmd_wr, cmd_go, bad_op, stat_rd;
  logic media_last, stop_now, fin, fin_err;
  logic [47:0] fin_lba;
  logic [15:0] fin_run;
  logic [7:0] fin_bits;
  logic [2:0] tf_ix;

  assign rd_fall = hb_q.rd_n && !hb_s2.rd_n;
  assign wr_rise = !hb_q.wr_n && hb_s2.wr_n;
  assign idle = (state == srsr_pkg::SRSR_IDLE);
  assign tf_ix = hb_s2.addr - 3'h1;
  assign cmd_wr = wr_rise && !hb_s2.ctl_sel && hb_s2.addr == `SRSR_A_STATCMD && idle;
  assign cmd_go = cmd_wr && hb_s2.din == `SRSR_OP_READ_STREAM;
  assign bad_op = cmd_wr && hb_s2.din != `SRSR_OP_READ_STREAM;
  assign stat_rd = rd_fall && !hb_s2.ctl_sel && hb_s2.addr == `SRSR_A_STATCMD;
  assign media_last = media.valid && (done_cnt + 17'h1 == requested);
  // without continuous read the first error ends the command
  assign stop_now = media.valid && media.err && !rc;
  assign fin = !idle && (tmo || media_last || stop_now);
  assign fin_err = err_seen || (media.valid && media.err);
  assign fin_lba = err_seen ? first_lba : media.lba;
  assign fin_run = err_seen ? run_len + 16'((in_run && media.valid && media.err) ? 1 : 0)
                            : 16'h0001;
  assign fin_bits = err_acc | ((media.valid && media.err) ? media.err_bits : 8'h00)
                    | (tmo ? 8'h01 << `SRSR_ER_COMPLETION_LIMIT_TIMEOUT_FLAG : 8'h00);

  srsr_completion_time_limit_timer #(
    .UNIT_US(COMPLETION_TIME_LIMIT_UNIT_US)
  ) u_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(cmd_go),
    .stop(fin),
    .limit(tf_prev[0]),
    .expired(tmo)
  );

  // command progress and first-error tracking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= srsr_pkg::SRSR_IDLE;
      rc <= 1'b0;
      requested <= 17'h0;
      done_cnt <= 17'h0;
      err_seen <= 1'b0;
      in_run <= 1'b0;
      first_lba <= 48'h0;
      run_len <= 16'h0;
      err_acc <= 8'h00;
    end else begin
      case (state)
        srsr_pkg::SRSR_IDLE: begin
          if (cmd_go) begin
            state <= srsr_pkg::SRSR_BUSY;
            rc <= tf_cur[0][`SRSR_FEAT_RC];
            requested <= ({tf_prev[1], tf_cur[1]} == 16'h0) ? `SRSR_CNT_MAX
                         : {1'b0, tf_prev[1], tf_cur[1]};
            done_cnt <= 17'h0;
            err_seen <= 1'b0;
            in_run <= 1'b0;
            run_len <= 16'h0;
            err_acc <= 8'h00;
          end
        end
        srsr_pkg::SRSR_BUSY: begin
          if (fin) begin
            state <= srsr_pkg::SRSR_IDLE;
          end
          if (media.valid) begin
            done_cnt <= done_cnt + 17'h1;
            if (media.err) begin
              err_acc <= err_acc | media.err_bits;
              if (!err_seen) begin
                first_lba <= media.lba;
                run_len <= 16'h0001;
                err_seen <= 1'b1;
                in_run <= 1'b1;
              end else if (in_run) begin
                run_len <= run_len + 16'h0001;
              end
            end else begin
              in_run <= 1'b0;
            end
          end
        end
        default: state <= srsr_pkg::SRSR_IDLE;
      endcase
    end
  end

  // task file; an errored finish overwrites address and count lanes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) begin
        tf_cur[i] <= `SRSR_TF_RST;
        tf_prev[i] <= `SRSR_TF_RST;
      end
      dev_head <= `SRSR_TF_RST;
    end else if (fin && fin_err) begin
      // deferred write failures never reach these lanes
      for (int i = 0; i < 3; i++) begin
        tf_cur[i + 2] <= fin_lba[8 * lane_of(i, 1'b0) +: 8];
        tf_prev[i + 2] <= fin_lba[8 * lane_of(i, 1'b1) +: 8];
      end
      tf_cur[1] <= fin_run[7:0];
      tf_prev[1] <= fin_run[15:8];
    end else if (wr_rise && !hb_s2.ctl_sel && idle) begin
      // writes while busy are dropped, as the host must wait for BSY=0
      if (hb_s2.addr >= `SRSR_A_ERRFEAT && hb_s2.addr <= `SRSR_A_CYLHI) begin
        tf_prev[tf_ix] <= tf_cur[tf_ix];
        tf_cur[tf_ix] <= hb_s2.din;
      end else if (hb_s2.addr == `SRSR_A_DEV) begin
        dev_head <= hb_s2.din;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hob <= 1'b0;
    end else if (wr_rise && hb_s2.ctl_sel && hb_s2.addr == `SRSR_A_DEVCTL) begin
      hob <= hb_s2.din[`SRSR_DEVCTL_HOB];
    end
  end

  // ending status, error register and error log
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_se <= 1'b0;
      st_dwe <= 1'b0;
      st_err <= 1'b0;
      err_reg <= 8'h00;
      log_valid <= 1'b0;
      log_bits <= 8'h00;
    end else begin
      log_valid <= 1'b0;
      if (cmd_go) begin
        st_se <= 1'b0;
        st_dwe <= 1'b0;
        st_err <= 1'b0;
        err_reg <= 8'h00;
      end else if (bad_op) begin
        st_err <= 1'b1;
        err_reg <= 8'h01 << `SRSR_ER_ABRT;
      end else if (fin) begin
        st_dwe <= dwe_pend || dwe_event;
        if (rc) begin
          st_se <= (fin_bits != 8'h00);
          st_err <= 1'b0;
          err_reg <= fin_bits & (8'h01 << `SRSR_ER_COMPLETION_LIMIT_TIMEOUT_FLAG);
          log_valid <= (fin_bits != 8'h00);
          log_bits <= fin_bits;
        end else begin
          st_err <= (fin_bits != 8'h00);
          err_reg <= fin_bits;
        end
      end
    end
  end

  // deferred write pending: a new event in the reporting cycle survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dwe_pend <= 1'b0;
    end else begin
      dwe_pend <= dwe_event || (dwe_pend && !fin);
    end
  end

  // interrupt: set wins over the clearing status read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intrq <= 1'b0;
    end else begin
      intrq <= fin || bad_op || (intrq && !stat_rd);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xfer_active <= 1'b0;
    end else begin
      xfer_active <= cmd_go || (!idle && !fin);
    end
  end

  logic [7:0] status_byte;
  assign status_byte = {!idle, idle, st_se, st_dwe, 3'b000, st_err};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hst_dout <= 8'h00;
      hst_doe <= 1'b0;
    end else if (rd_fall) begin
      hst_doe <= 1'b1;
      if (hb_s2.ctl_sel) begin
        hst_dout <= (hb_s2.addr == `SRSR_A_DEVCTL) ? status_byte : 8'h00;
      end else if (hb_s2.addr == `SRSR_A_ERRFEAT) begin
        hst_dout <= err_reg;
      end else if (hb_s2.addr >= `SRSR_A_COUNT && hb_s2.addr <= `SRSR_A_CYLHI) begin
        hst_dout <= hob ? tf_prev[tf_ix] : tf_cur[tf_ix];
      end else if (hb_s2.addr == `SRSR_A_DEV) begin
        hst_dout <= dev_head;
      end else if (hb_s2.addr == `SRSR_A_STATCMD) begin
        hst_dout <= status_byte;
      end else begin
        hst_dout <= 8'h00;
      end
    end else if (hb_s2.rd_n) begin
      hst_doe <= 1'b0;
    end
  end

  a_lba_low_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    fin && fin_err |=> tf_cur[2] == fin_lba[7:0] && tf_cur[3] == fin_lba[15:8])
    else $error("low lanes wrong");
  a_lba_hob_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    fin && fin_err |=> tf_prev[2] == $past(fin_lba[31:24]) && tf_prev[3] == $past(fin_lba[39:32]))
    else $error("hob lanes wrong");
  a_lba_high_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    fin && fin_err |=> tf_cur[4] == $past(fin_lba[23:16]) && tf_prev[4] == $past(fin_lba[47:40]))
    else $error("cyl high lanes wrong");
  a_timeout_flag: assert property (@(posedge ref_clk) disable iff (rst)
    fin && tmo |=> err_reg[`SRSR_ER_COMPLETION_LIMIT_TIMEOUT_FLAG] && idle) else $error("timeout not flagged");
  a_stream_err: assert property (@(posedge ref_clk) disable iff (rst)
    fin && rc && fin_err |=> st_se && !st_err && log_valid) else $error("stream error wrong");
  a_run_count: assert property (@(posedge ref_clk) disable iff (rst)
    fin && fin_err |=> {tf_prev[1], tf_cur[1]} == $past(fin_run)) else $error("run count wrong");
  // a failure pending or arriving at the end is reported at that end
  a_dwe_report: assert property (@(posedge ref_clk) disable iff (rst)
    fin && (dwe_pend || dwe_event) |=> st_dwe) else $error("deferred error lost");
  a_dwe_no_lba: assert property (@(posedge ref_clk) disable iff (rst)
    fin && !fin_err |=> $stable(tf_cur[2]) && $stable(tf_prev[4])) else $error("lanes touched");
  a_zero_count: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_go && tf_cur[1] == 8'h00 && tf_prev[1] == 8'h00 |=> requested == 17'h10000)
    else $error("zero count not 65536");
  a_irq_at_end: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_go |=> !intrq ##0 !idle) else $error("interrupt before end");

  c_clean_end: cover property (@(posedge ref_clk) disable iff (rst) fin && !fin_err);
  c_rc_error: cover property (@(posedge ref_clk) disable iff (rst) fin && rc && fin_err);
  c_timeout: cover property (@(posedge ref_clk) disable iff (rst) fin && tmo);
  c_dwe_end: cover property (@(posedge ref_clk) disable iff (rst) fin && dwe_pend);

endmodule : srsr_top

// ===== bench/srsr_host_model.sv
/*
  host controller model: drives the task-file strobes, address and data.
  assumes the device answers reads on hst_doe within a few ref_clk cycles.
*/
`timescale 1ns/1ns

module srsr_host_model (
  input wire logic ref_clk,
  output logic hst_ctl_sel,
  output logic [2:0] hst_addr,
  output logic hst_rd_n,
  output logic hst_wr_n,
  output logic [7:0] hst_din,
  input wire logic [7:0] hst_dout,
  input wire logic hst_doe
);
  initial begin
    hst_ctl_sel = 1'b0;
    hst_addr = 3'h0;
    hst_rd_n = 1'b1;
    hst_wr_n = 1'b1;
    hst_din = 8'hff;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // strobes low and high for 2 cycles at least; data held past the sync delay
  task automatic wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
    tick(1);
    hst_ctl_sel = ctl;
    hst_addr = a;
    hst_din = d;
    hst_wr_n = 1'b0;
    tick(2);
    hst_wr_n = 1'b1;
    tick(4);
    // released data bus never shows the last value
    hst_din = ~d;
    tick(2);
  endtask : wr

  // hold the strobe until doe is seen, take dout at that edge
  task automatic rd(input logic ctl, input logic [2:0] a, output logic [7:0] d);
    int n;
    tick(1);
    hst_ctl_sel = ctl;
    hst_addr = a;
    hst_rd_n = 1'b0;
    n = 0;
    d = 8'hxx;
    while (hst_doe !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (hst_doe === 1'b1) begin
      d = hst_dout;
    end
    hst_rd_n = 1'b1;
    n = 0;
    while (hst_doe !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    tick(2);
  endtask : rd
endmodule : srsr_host_model

// ===== bench/stream_read_status_report_test.sv
/*
  self-checking bench for the stream-read status reporter.
  assumes srsr_host_model on the task-file pins; media and dwe_event from here.
*/
`timescale 1ns/1ns
`include "srsr_defs.svh"

module stream_read_status_report_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hst_ctl_sel, hst_rd_n, hst_wr_n, hst_doe, intrq, xfer_active, log_valid;
  logic [2:0] hst_addr;
  logic [7:0] hst_din, hst_dout, log_bits, log_last;
  logic dwe_event = 1'b0;
  srsr_pkg::srsr_media_t media = '0;
  int errors = 0;
  int tests_run = 0;
  int log_seen = 0;

  always #2 ref_clk = ~ref_clk;

  srsr_top #(.COMPLETION_TIME_LIMIT_UNIT_US(1)) u_srsr_top (
    .ref_clk(ref_clk), .rst(rst), .hst_ctl_sel(hst_ctl_sel), .hst_addr(hst_addr),
    .hst_rd_n(hst_rd_n), .hst_wr_n(hst_wr_n), .hst_din(hst_din), .hst_dout(hst_dout),
    .hst_doe(hst_doe), .intrq(intrq), .media(media), .dwe_event(dwe_event),
    .xfer_active(xfer_active), .log_valid(log_valid), .log_bits(log_bits));

  srsr_host_model u_srsr_host_model (
    .ref_clk(ref_clk), .hst_ctl_sel(hst_ctl_sel), .hst_addr(hst_addr),
    .hst_rd_n(hst_rd_n), .hst_wr_n(hst_wr_n), .hst_din(hst_din),
    .hst_dout(hst_dout), .hst_doe(hst_doe));

  always @(posedge ref_clk) begin
    if (log_valid === 1'b1) begin
      log_seen <= log_seen + 1;
      log_last <= log_bits;
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic hw(input logic ctl, input logic [2:0] a, input logic [7:0] d);
    u_srsr_host_model.wr(ctl, a, d);
  endtask : hw

  task automatic rdc(input logic ctl, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_srsr_host_model.rd(ctl, a, d);
    chk(d, e);
  endtask : rdc

  task automatic hob(input logic v);
    hw(1'b1, `SRSR_A_DEVCTL, {v, 7'h00});
  endtask : hob

  // previous byte first, then current
  task automatic issue(input logic [7:0] lim, input logic [7:0] feat, input logic [15:0] cnt);
    hw(1'b0, `SRSR_A_ERRFEAT, lim);
    hw(1'b0, `SRSR_A_ERRFEAT, feat);
    hw(1'b0, `SRSR_A_COUNT, cnt[15:8]);
    hw(1'b0, `SRSR_A_COUNT, cnt[7:0]);
    hw(1'b0, `SRSR_A_STATCMD, `SRSR_OP_READ_STREAM);
  endtask : issue

  task automatic sector(input logic [47:0] lba, input logic [7:0] bits);
    media.valid = 1'b1;
    media.err = (bits != 8'h00);
    media.err_bits = bits;
    media.lba = lba;
    tick(1);
    media = {1'b0, 1'b0, ~bits, ~lba};
    tick(1);
  endtask : sector

  task automatic wait_end(input logic [7:0] st);
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    rdc(1'b0, `SRSR_A_STATCMD, st);
  endtask : wait_end

  task automatic test_first_error_lanes;
    issue(8'h00, 8'h00, 16'h0004);
    sector(48'h000000000001, 8'h00);
    sector(48'habcdef123456, 8'h40);
    wait_end(8'h41);
    rdc(1'b0, `SRSR_A_ERRFEAT, 8'h40);
    rdc(1'b0, `SRSR_A_SECT, 8'h56);
    rdc(1'b0, `SRSR_A_CYLLO, 8'h34);
    rdc(1'b0, `SRSR_A_CYLHI, 8'h12);
    hob(1'b1);
    rdc(1'b0, `SRSR_A_SECT, 8'hef);
    rdc(1'b0, `SRSR_A_CYLLO, 8'hcd);
    rdc(1'b0, `SRSR_A_CYLHI, 8'hab);
    hob(1'b0);
  endtask : test_first_error_lanes

  // errors do not stop a continuous read; a run of two bad sectors
  task automatic test_continuous_errors;
    int base;
    // log_seen has one driver; count from where it stands now
    base = log_seen;
    issue(8'h00, 8'h40, 16'h0004);
    sector(48'h5a5a0000001f, 8'h00);
    sector(48'h5a5a00000020, 8'h40);
    sector(48'h5a5a00000021, 8'h80);
    tick(4);
    chk({7'h0, intrq}, 8'h00);
    sector(48'h5a5a00000022, 8'h00);
    wait_end(8'h60);
    rdc(1'b0, `SRSR_A_ERRFEAT, 8'h00);
    chk(8'(log_seen - base), 8'h01);
    chk(log_last, 8'hc0);
    rdc(1'b0, `SRSR_A_SECT, 8'h20);
    rdc(1'b0, `SRSR_A_COUNT, 8'h02);
    hob(1'b1);
    rdc(1'b0, `SRSR_A_CYLHI, 8'h5a);
    rdc(1'b0, `SRSR_A_COUNT, 8'h00);
    hob(1'b0);
  endtask : test_continuous_errors

  // limit 1 unit of 1 us is 250 cycles from the command write
  task automatic test_time_limit;
    int n;
    issue(8'h01, 8'h40, 16'h0008);
    n = 0;
    while (intrq !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk({7'h0, n >= 240 && n <= 256}, 8'h01);
    wait_end(8'h60);
    rdc(1'b0, `SRSR_A_ERRFEAT, 8'h01);
  endtask : test_time_limit

  task automatic test_deferred_write;
    dwe_event = 1'b1;
    tick(1);
    dwe_event = 1'b0;
    issue(8'h00, 8'h00, 16'h0001);
    sector(48'h000000000077, 8'h00);
    wait_end(8'h50);
    // reported once, then cleared
    issue(8'h00, 8'h00, 16'h0001);
    sector(48'h000000000078, 8'h00);
    wait_end(8'h40);
    // lanes still hold the stream error address from earlier
    rdc(1'b0, `SRSR_A_SECT, 8'h20);
  endtask : test_deferred_write

  // an unknown opcode is refused with abort and ends at once
  task automatic test_bad_opcode;
    hw(1'b0, `SRSR_A_STATCMD, 8'h20);
    wait_end(8'h41);
    rdc(1'b0, `SRSR_A_ERRFEAT, 8'h04);
  endtask : test_bad_opcode

  // valid held high counts one sector per cycle
  task automatic test_zero_count;
    issue(8'h00, 8'h00, 16'h0000);
    media.valid = 1'b1;
    tick(65535);
    media.valid = 1'b0;
    tick(4);
    chk({7'h0, intrq}, 8'h00);
    chk({7'h0, xfer_active}, 8'h01);
    sector(48'h000000000000, 8'h00);
    wait_end(8'h40);
    chk({7'h0, xfer_active}, 8'h00);
  endtask : test_zero_count

  initial begin
    #400000;
    errors++;
    test_done();
  end

  initial begin
    tick(16);
    rst = 1'b0;
    tick(4);
    test_first_error_lanes();
    test_continuous_errors();
    test_time_limit();
    test_deferred_write();
    test_bad_opcode();
    test_zero_count();
    test_done();
  end
endmodule : stream_read_status_report_test
